// file: src/fpc_pkg.sv
// Package: register map, field positions, codes and timing for the flash controller
package fpc_pkg;

    // Register word addresses (byte address = offset)
    localparam logic [7:0]  FPC_CTRL_OFS   = 8'h00;  // flash_op_control
    localparam logic [7:0]  FPC_KEY_OFS    = 8'h04;  // flash_unlock_key, write only
    localparam logic [7:0]  FPC_PAGE_OFS   = 8'h08;  // table_page_reg
    localparam logic [7:0]  FPC_PTR_OFS    = 8'h0C;  // pointer effective address
    localparam logic [7:0]  FPC_LATLO_OFS  = 8'h10;  // latch write, low word
    localparam logic [7:0]  FPC_LATHI_OFS  = 8'h14;  // latch write, high byte

    // Control register fields
    localparam int          FPC_START_BIT  = 15;
    localparam int          FPC_WALLOW_BIT = 14;
    localparam int          FPC_SEQERR_BIT = 13;
    localparam int          FPC_ERASE_BIT  = 6;
    localparam logic [15:0] FPC_CTRL_RST   = 16'h0000;

    // Unlock keys
    localparam logic [7:0]  FPC_KEY1       = 8'h55;
    localparam logic [7:0]  FPC_KEY2       = 8'hAA;

    // Operation select codes
    localparam logic [3:0]  FPC_OP_BULK    = 4'hF;
    localparam logic [3:0]  FPC_OP_WORD    = 4'h3;
    localparam logic [3:0]  FPC_OP_PAGE    = 4'h2;
    localparam logic [3:0]  FPC_OP_ROW     = 4'h1;

    // Geometry: 64-word rows, 512-word erase blocks, 24-bit instructions
    localparam int          FPC_ROW_WORDS  = 64;
    localparam int          FPC_ROW_AW     = 6;
    localparam int          FPC_BLK_AW     = 9;
    localparam int          FPC_WORD_W     = 24;

    // Array command codes toward the flash array
    typedef enum logic [2:0] {
        FPC_CMD_NONE = 3'b000,
        FPC_CMD_WORD = 3'b001,
        FPC_CMD_ROW  = 3'b010,
        FPC_CMD_PAGE = 3'b011,
        FPC_CMD_BULK = 3'b100
    } fpc_cmd_e;

    // Controller states
    typedef enum logic [1:0] {
        FPC_ST_IDLE = 2'b00,
        FPC_ST_RUN  = 2'b01,
        FPC_ST_WAIT = 2'b10
    } fpc_state_e;

    // Ack latency of the bus slave
    localparam int          FPC_ACK_CYC    = 1;

endpackage : fpc_pkg

// file: src/fpc_latch_mem.sv
// Holding latch memory: one row of program words, registered read
module fpc_latch_mem (
    input  wire logic                        clk_i,
    input  wire logic                        wr_lo_i,
    input  wire logic                        wr_hi_i,
    input  wire logic [fpc_pkg::FPC_ROW_AW-1:0] waddr_i,
    input  wire logic [15:0]                 wdata_i,
    input  wire logic [fpc_pkg::FPC_ROW_AW-1:0] raddr_i,
    output logic      [fpc_pkg::FPC_WORD_W-1:0] rdata_o
);
    import fpc_pkg::*;

    logic [FPC_WORD_W-1:0] mem_q [FPC_ROW_WORDS];

    // Low word and high byte are written separately, like the two table writes
    always_ff @(posedge clk_i) begin
        if (wr_lo_i) begin
            mem_q[waddr_i][15:0] <= wdata_i;
        end
        if (wr_hi_i) begin
            mem_q[waddr_i][23:16] <= wdata_i[7:0];
        end
        rdata_o <= mem_q[raddr_i];
    end

endmodule : fpc_latch_mem

// file: src/fpc_ctrl.sv
// Flash program/erase controller: Wishbone registers, unlock, sequencing, array port
module fpc_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    input  wire logic        serial_prog_mode_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Processor stall
    output logic             cpu_stall_o,
    // Flash array side
    output logic      [2:0]  arr_cmd_o,
    output logic             arr_start_o,
    output logic      [23:0] arr_addr_o,
    output logic      [23:0] arr_wdata_o,
    output logic      [5:0]  arr_widx_o,
    input  wire logic        arr_done_i
);
    import fpc_pkg::*;

    // Register state
    logic        start_q,  start_d;
    logic        wallow_q, wallow_d;
    logic        seqerr_q, seqerr_d;
    logic        erase_q,  erase_d;
    logic [3:0]  opsel_q,  opsel_d;
    logic [7:0]  page_q;
    logic [15:0] ptr_q;
    logic        key1_q,   key1_d;   // First key seen, waiting for second
    logic        armed_q,  armed_d;  // Both keys seen, next write may start
    logic        ack_q;
    logic [31:0] rdat_q;
    fpc_state_e  state_q,  state_d;
    fpc_cmd_e    cmd_q;
    logic [5:0]  widx_q;
    logic [23:0] latch_rd;

    // Bus decode
    wire         bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         bus_wr    = bus_req & wb_we_i;
    wire         lo_lanes  = wb_sel_i[0] & wb_sel_i[1];
    wire         hit_ctrl  = (wb_adr_i == FPC_CTRL_OFS);
    wire         hit_key   = (wb_adr_i == FPC_KEY_OFS);
    wire         hit_page  = (wb_adr_i == FPC_PAGE_OFS);
    wire         hit_ptr   = (wb_adr_i == FPC_PTR_OFS);
    wire         hit_latlo = (wb_adr_i == FPC_LATLO_OFS);
    wire         hit_lathi = (wb_adr_i == FPC_LATHI_OFS);
    wire         wr_ctrl   = bus_wr & hit_ctrl & lo_lanes;
    wire         wr_key    = bus_wr & hit_key & wb_sel_i[0];
    wire         busy      = (state_q != FPC_ST_IDLE);

    // Control image; unimplemented bits tie to zero
    wire  [15:0] ctrl_img  = {start_q, wallow_q, seqerr_q, 6'h00, erase_q, 2'h0, opsel_q};

    // Start request and its qualification
    wire         set_try   = wr_ctrl & wb_dat_i[FPC_START_BIT] & ~start_q;
    wire         new_wall  = wb_dat_i[FPC_WALLOW_BIT];
    wire         new_era   = wb_dat_i[FPC_ERASE_BIT];
    wire  [3:0]  new_op    = wb_dat_i[3:0];
    wire         go_ok     = set_try & armed_q & new_wall;
    wire         go_bad    = set_try & ~(armed_q & new_wall);

    // Operation decode: each defined code has one valid erase setting
    fpc_cmd_e    dec_cmd;
    always_comb begin
        case (new_op)
            FPC_OP_BULK: dec_cmd = (new_era & serial_prog_mode_i) ? FPC_CMD_BULK
                                                                 : FPC_CMD_NONE;
            FPC_OP_WORD: dec_cmd = new_era ? FPC_CMD_NONE : FPC_CMD_WORD;
            FPC_OP_PAGE: dec_cmd = new_era ? FPC_CMD_PAGE : FPC_CMD_NONE;
            FPC_OP_ROW:  dec_cmd = new_era ? FPC_CMD_NONE : FPC_CMD_ROW;
            default:     dec_cmd = FPC_CMD_NONE;
        endcase
    end

    // Unlock tracking: armed only by 55h directly followed by AAh
    always_comb begin
        key1_d  = key1_q;
        armed_d = armed_q;
        if (wr_key) begin
            key1_d  = (wb_dat_i[7:0] == FPC_KEY1);
            armed_d = key1_q & (wb_dat_i[7:0] == FPC_KEY2);
        end else if (bus_wr) begin
            key1_d  = 1'b0;
            armed_d = 1'b0;  // Any other write breaks the sequence
        end
    end

    // Control field next values; software cannot clear start
    always_comb begin
        start_d  = start_q;
        wallow_d = wallow_q;
        seqerr_d = seqerr_q;
        erase_d  = erase_q;
        opsel_d  = opsel_q;
        if (wr_ctrl & ~busy) begin
            wallow_d = new_wall;
            erase_d  = new_era;
            opsel_d  = new_op;
        end
        if (go_ok) begin
            start_d  = 1'b1;
            seqerr_d = 1'b0;
        end
        if (go_bad) begin
            seqerr_d = 1'b1;
        end
        if (state_q == FPC_ST_WAIT && arr_done_i) begin
            start_d  = 1'b0;
        end
        if (state_q == FPC_ST_RUN && cmd_q == FPC_CMD_NONE) begin
            start_d  = 1'b0;  // No-op code completes at once
        end
        // Operation cut off by a system reset: end it and flag the bad end
        // Left alone, start would stay set and lock out every later start
        if (start_q && state_q == FPC_ST_IDLE) begin
            start_d  = 1'b0;
            seqerr_d = 1'b1;
        end
    end

    // Control bits reset on power-on only, not on the system reset
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            start_q  <= FPC_CTRL_RST[FPC_START_BIT];
            wallow_q <= FPC_CTRL_RST[FPC_WALLOW_BIT];
            seqerr_q <= FPC_CTRL_RST[FPC_SEQERR_BIT];
            erase_q  <= FPC_CTRL_RST[FPC_ERASE_BIT];
            opsel_q  <= FPC_CTRL_RST[3:0];
        end else begin
            start_q  <= start_d;
            wallow_q <= wallow_d;
            seqerr_q <= seqerr_d;
            erase_q  <= erase_d;
            opsel_q  <= opsel_d;
        end
    end

    // Sequencer: stall the core until the array reports done
    always_comb begin
        state_d = state_q;
        case (state_q)
            FPC_ST_IDLE: state_d = go_ok ? FPC_ST_RUN : FPC_ST_IDLE;
            FPC_ST_RUN:  state_d = (cmd_q == FPC_CMD_NONE) ? FPC_ST_IDLE : FPC_ST_WAIT;
            FPC_ST_WAIT: state_d = arr_done_i ? FPC_ST_IDLE : FPC_ST_WAIT;
            default:     state_d = FPC_ST_IDLE;
        endcase
    end

    // Unlock, sequencer and address registers; cleared on either reset
    always_ff @(posedge clk_i) begin
        if (rst_i | por_i) begin
            state_q <= FPC_ST_IDLE;
            cmd_q   <= FPC_CMD_NONE;
            key1_q  <= 1'b0;
            armed_q <= 1'b0;
            page_q  <= 8'h00;
            ptr_q   <= 16'h0000;
            widx_q  <= 6'h00;
        end else begin
            state_q <= state_d;
            key1_q  <= key1_d;
            armed_q <= armed_d;
            if (go_ok) begin
                cmd_q <= dec_cmd;
            end
            if (bus_wr & hit_page & wb_sel_i[0]) begin
                page_q <= wb_dat_i[7:0];
            end
            if (bus_wr & hit_ptr & lo_lanes) begin
                ptr_q <= wb_dat_i[15:0];
            end
            // Row streaming index walks the latches while the array runs
            if (state_q == FPC_ST_WAIT) begin
                widx_q <= widx_q + 6'h01;
            end else begin
                widx_q <= 6'h00;
            end
        end
    end

    // Holding latches: table writes land here, never in the array
    fpc_latch_mem u_latch (
        .clk_i   (clk_i),
        .wr_lo_i (bus_wr & hit_latlo & lo_lanes & ~busy),
        .wr_hi_i (bus_wr & hit_lathi & wb_sel_i[0] & ~busy),
        .waddr_i (ptr_q[FPC_ROW_AW:1]),
        .wdata_i (wb_dat_i[15:0]),
        .raddr_i (widx_q),
        .rdata_o (latch_rd)
    );

    // Target address: page high, pointer low, aligned by operation
    wire  [23:0] raw_addr  = {page_q, ptr_q};
    wire  [23:0] blk_addr  = {raw_addr[23:FPC_BLK_AW+1], {(FPC_BLK_AW+1){1'b0}}};
    wire  [23:0] row_addr  = {raw_addr[23:FPC_ROW_AW+1], {(FPC_ROW_AW+1){1'b0}}};
    // Latched on the accepted start, so the target stands with the array strobe
    always_ff @(posedge clk_i) begin
        if (rst_i | por_i) begin
            arr_addr_o <= 24'h000000;
        end else if (go_ok) begin
            case (dec_cmd)
                FPC_CMD_PAGE: arr_addr_o <= blk_addr;   // last page not blocked
                FPC_CMD_ROW:  arr_addr_o <= row_addr;
                FPC_CMD_BULK: arr_addr_o <= 24'h000000;
                default:      arr_addr_o <= raw_addr;
            endcase
        end
    end

    // Array strobe is one pulse on the RUN cycle; data streams from latches
    assign arr_start_o = (state_q == FPC_ST_RUN) & (cmd_q != FPC_CMD_NONE);
    assign arr_cmd_o   = cmd_q;
    assign arr_wdata_o = latch_rd;
    assign arr_widx_o  = widx_q;
    assign cpu_stall_o = busy;

    // Wishbone answer: one-cycle ack, unmapped reads return zero
    wire  [31:0] rd_mux = hit_ctrl  ? {16'h0000, ctrl_img} :
                          hit_page  ? {24'h000000, page_q} :
                          hit_ptr   ? {16'h0000, ptr_q}    :
                          32'h00000000;                                // Key reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i | por_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q  <= bus_req;
            rdat_q <= (bus_req & ~wb_we_i) ? rd_mux : 32'h00000000;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Checks
    property p_start_needs_unlock;
        @(posedge clk_i) disable iff (rst_i | por_i)
        $rose(start_q) |-> $past(armed_q) && $past(wallow_d);
    endproperty
    a_start_needs_unlock: assert property (p_start_needs_unlock)
        else $error("start set without unlock");

    property p_bad_try_flags;
        @(posedge clk_i) disable iff (rst_i | por_i)
        go_bad |=> seqerr_q && (state_q == FPC_ST_IDLE);
    endproperty
    a_bad_try_flags: assert property (p_bad_try_flags)
        else $error("bad start did not flag error");

    property p_stall_while_busy;
        @(posedge clk_i) disable iff (rst_i | por_i)
        go_ok |=> cpu_stall_o && start_q;
    endproperty
    a_stall_while_busy: assert property (p_stall_while_busy)
        else $error("core not stalled during operation");

    property p_done_clears;
        @(posedge clk_i) disable iff (rst_i | por_i)
        (state_q == FPC_ST_WAIT) && arr_done_i |=> !start_q && !cpu_stall_o;
    endproperty
    a_done_clears: assert property (p_done_clears)
        else $error("start not cleared on done");

    property p_no_sw_clear;
        @(posedge clk_i) disable iff (rst_i | por_i)
        start_q && (state_q == FPC_ST_WAIT) && !arr_done_i |=> start_q;
    endproperty
    a_no_sw_clear: assert property (p_no_sw_clear)
        else $error("start cleared early");

    property p_bad_code_idle;
        @(posedge clk_i) disable iff (rst_i | por_i)
        go_ok && dec_cmd == FPC_CMD_NONE |=> ##1 !busy && !arr_start_o;
    endproperty
    a_bad_code_idle: assert property (p_bad_code_idle)
        else $error("invalid code started flash");

    property p_key_reads_zero;
        @(posedge clk_i) disable iff (rst_i | por_i)
        bus_req && !wb_we_i && hit_key |=> wb_dat_o == 32'h00000000;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero)
        else $error("key register readable");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i | por_i)
        bus_req && !wb_we_i && hit_ctrl |=> wb_dat_o[12:7] == 6'h00 && wb_dat_o[5:4] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits nonzero");

    property p_key_break;
        @(posedge clk_i) disable iff (rst_i | por_i)
        wr_key && wb_dat_i[7:0] != FPC_KEY2 |=> !armed_q;
    endproperty
    a_key_break: assert property (p_key_break)
        else $error("wrong key left armed");

    // Not disabled by the system reset: the abort it watches follows one
    property p_abort_flags;
        @(posedge clk_i) disable iff (por_i)
        start_q && !busy |=> !start_q && seqerr_q;
    endproperty
    a_abort_flags: assert property (p_abort_flags)
        else $error("aborted operation left start set");

    c_row_prog:   cover property (@(posedge clk_i) arr_start_o && cmd_q == FPC_CMD_ROW);
    c_page_erase: cover property (@(posedge clk_i) arr_start_o && cmd_q == FPC_CMD_PAGE);
    c_word_prog:  cover property (@(posedge clk_i) arr_start_o && cmd_q == FPC_CMD_WORD);
    c_seq_error:  cover property (@(posedge clk_i) go_bad);
    c_abort:      cover property (@(posedge clk_i) start_q && !busy);

endmodule : fpc_ctrl

// file: tb/fpc_array_model.sv
// Flash array stand-in: records launches and answers done after a set delay
module fpc_array_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        arr_start_i,
    input  wire logic [2:0]  arr_cmd_i,
    input  wire logic [23:0] arr_addr_i,
    input  wire logic [7:0]  delay_i,
    output logic             arr_done_o,
    output int               starts_o,
    output logic      [2:0]  last_cmd_o,
    output logic      [23:0] last_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_q;
    logic       busy_q;

    // Self-timed op: one done pulse delay_i cycles after launch, prompt or slow
    always_ff @(posedge clk_i) begin
        arr_done_o <= 1'b0;
        if (rst_i) begin
            busy_q   <= 1'b0;
            cnt_q    <= 8'h00;
            starts_o <= 0;
        end else if (arr_start_i) begin
            busy_q      <= 1'b1;
            cnt_q       <= delay_i;
            starts_o    <= starts_o + 1;
            last_cmd_o  <= arr_cmd_i;
            last_addr_o <= arr_addr_i;
        end else if (busy_q && cnt_q <= 8'h01) begin
            busy_q     <= 1'b0;
            arr_done_o <= 1'b1;  // Termination of the stalled operation
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

endmodule : fpc_array_model

// file: tb/tb_fpc_ctrl.sv
// Self-checking bench for the flash program/erase controller
module tb_fpc_ctrl;
    import fpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        por_i = 1'b1;
    logic        ser_i = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, cpu_stall_o, arr_start_o, arr_done_i;
    logic [2:0]  arr_cmd_o, last_cmd;
    logic [23:0] arr_addr_o, arr_wdata_o, last_addr;
    logic [5:0]  arr_widx_o;
    logic [7:0]  dly = 8'h28;
    int          starts, fails = 0, checked = 0, cycles = 0;

    always #2 clk_i = ~clk_i;

    fpc_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .serial_prog_mode_i(ser_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_stall_o(cpu_stall_o),
        .arr_cmd_o(arr_cmd_o), .arr_start_o(arr_start_o), .arr_addr_o(arr_addr_o),
        .arr_wdata_o(arr_wdata_o), .arr_widx_o(arr_widx_o), .arr_done_i(arr_done_i));

    fpc_array_model u_arr (.clk_i(clk_i), .rst_i(rst_i), .arr_start_i(arr_start_o),
        .arr_cmd_i(arr_cmd_o), .arr_addr_i(arr_addr_o), .delay_i(dly),
        .arr_done_o(arr_done_i), .starts_o(starts), .last_cmd_o(last_cmd),
        .last_addr_o(last_addr));

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard: whole run needs about 1300 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Classic single cycle; request held until ack is sampled at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic unlock;
        wb(1'b1, FPC_KEY_OFS, 32'h55);
        wb(1'b1, FPC_KEY_OFS, 32'hAA);
    endtask : unlock

    // Optional unlock, start word, watch stall and array, then read control back
    task automatic start_op(input logic [15:0] w, input bit unl, input logic [2:0] cmd,
                            input logic [15:0] exp_ctrl);
        int s0;
        int stl;
        s0  = starts;
        stl = 0;
        if (unl) unlock();
        wb(1'b1, FPC_CTRL_OFS, {16'h0, w});
        repeat (int'(dly) + 20) begin
            @(posedge clk_i);
            if (cpu_stall_o === 1'b1) stl++;
        end
        chk("launches", 32'(cmd != FPC_CMD_NONE), 32'(starts - s0));
        if (cmd != FPC_CMD_NONE) begin
            chk("array command", 32'(cmd), 32'(last_cmd));
            chk("stall length", 32'h1, 32'(stl >= int'(dly)));
        end else begin
            chk("stall without op", 32'h1, 32'(stl <= 2));
        end
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("control", {16'h0, exp_ctrl}, rdat);
    endtask : start_op

    task automatic t_reset_values;
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("control at power-on", 32'h0, rdat);
        wb(1'b1, FPC_KEY_OFS, 32'h55);
        wb(1'b0, FPC_KEY_OFS, 32'h0);
        chk("key readback", 32'h0, rdat);
        wb(1'b0, 8'h3C, 32'h0);
        chk("unmapped read", 32'h0, rdat);
    endtask : t_reset_values

    // Refused starts: no unlock, no write-allow, broken key pair
    task automatic t_bad_starts;
        start_op(16'hC042, 1'b0, FPC_CMD_NONE, 16'h6042);
        wb(1'b1, FPC_CTRL_OFS, 32'h7FFF);
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("reserved bits", 32'h604F, rdat);
        start_op(16'h8042, 1'b1, FPC_CMD_NONE, 16'h2042);
        wb(1'b1, FPC_KEY_OFS, 32'h55);
        wb(1'b1, FPC_KEY_OFS, 32'h12);
        wb(1'b1, FPC_KEY_OFS, 32'hAA);
        start_op(16'hC042, 1'b0, FPC_CMD_NONE, 16'h6042);
    endtask : t_bad_starts

    // Block erase then row program, addressed by page and pointer
    task automatic t_erase_program;
        int s0;
        wb(1'b1, FPC_PAGE_OFS, 32'h02);
        wb(1'b1, FPC_PTR_OFS, 32'h0800);
        start_op(16'hC042, 1'b1, FPC_CMD_PAGE, 16'h4042);
        chk("erase target", 32'h020800, 32'(last_addr));
        dly = 8'h03;
        s0  = starts;
        for (int i = 0; i < FPC_ROW_WORDS; i++) begin
            wb(1'b1, FPC_PTR_OFS, 32'h0800 + 32'(2 * i));
            wb(1'b1, FPC_LATLO_OFS, 32'hBEEF);
            wb(1'b1, FPC_LATHI_OFS, 32'h5A);
        end
        chk("latch writes launch nothing", 32'(s0), 32'(starts));
        chk("latch word", 32'h005ABEEF, 32'(arr_wdata_o));
        chk("latch index idle", 32'h0, 32'(arr_widx_o));
        wb(1'b1, FPC_PTR_OFS, 32'h0800);
        start_op(16'hC001, 1'b1, FPC_CMD_ROW, 16'h4001);
        chk("row target", 32'h020800, 32'(last_addr));
        start_op(16'hC003, 1'b1, FPC_CMD_WORD, 16'h4003);
    endtask : t_erase_program

    // Every code in its idle variant, an undefined code, bulk erase both modes
    task automatic t_codes;
        logic [15:0] w [5] = '{16'hC041, 16'hC002, 16'hC043, 16'hC00F, 16'hC045};
        foreach (w[i]) start_op(w[i], 1'b1, FPC_CMD_NONE, w[i] & 16'h7FFF);
        ser_i <= 1'b1;
        start_op(16'hC04F, 1'b1, FPC_CMD_BULK, 16'h404F);
        chk("bulk target", 32'h0, 32'(last_addr));
        ser_i <= 1'b0;
        start_op(16'hC04F, 1'b1, FPC_CMD_NONE, 16'h404F);
    endtask : t_codes

    // Busy: start reads one, software clear ignored; plain reset keeps bits when idle, ends a running op with seqerr set
    task automatic t_busy_and_reset;
        dly = 8'h28;
        unlock();
        wb(1'b1, FPC_CTRL_OFS, 32'hC003);
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("start while busy", 32'h1, 32'(rdat[FPC_START_BIT]));
        wb(1'b1, FPC_CTRL_OFS, 32'h4003);
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("start after clear attempt", 32'h1, 32'(rdat[FPC_START_BIT]));
        repeat (60) @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("control after system reset", 32'h4003, rdat);
        unlock();
        wb(1'b1, FPC_CTRL_OFS, 32'hC003);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("control after aborted op", 32'h6003, rdat);
        chk("stall after aborted op", 32'h0, 32'(cpu_stall_o));
        por_i <= 1'b1;
        @(posedge clk_i);
        por_i <= 1'b0;
        wb(1'b0, FPC_CTRL_OFS, 32'h0);
        chk("control after power-on", 32'h0, rdat);
    endtask : t_busy_and_reset

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        t_reset_values();
        t_bad_starts();
        t_erase_program();
        t_codes();
        t_busy_and_reset();
        report_and_stop();
    end
endmodule : tb_fpc_ctrl
